/* File: rtl/dpc_consts.vh */
// dpc_consts.vh: constants for the dual pulse counter with hold
// assumes a 25 MHz system clock; included by bare name
`ifndef DPC_CONSTS_VH
`define DPC_CONSTS_VH

`define DPC_CLK_HZ        25000000
`define DPC_IN_MIN_US     1000
`define DPC_OUT_MIN_US    4000
`define DPC_OUT_MARGIN_US 100
`define DPC_MAX_RATE_HZ   128
`define DPC_CNT_MAX       28'h9999999
`define DPC_CNT_ZERO      28'h0000000
`define DPC_CNT_W         28
`define DPC_KEY_DB_US     20000

`endif

/* File: rtl/dpc_pulse_out.v */
// dpc_pulse_out.v: one output channel, stretches each input event into a pulse, dropping events that arrive while 15 are queued
// assumes events arrive on the same clock as one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
`include "dpc_consts.vh"

module dpc_pulse_out #(
    parameter integer HI_CYCLES  = 102500,
    parameter integer PEND_W     = 4
) (
    input  wire sys_clk_in,
    input  wire sys_rst_in,
    input  wire event_in,
    output wire pulse_out
);
    reg [16:0]       width_r;
    reg              busy_r;
    reg [PEND_W-1:0] pend_r;

    // each event makes one output pulse; events during a pulse queue in pend_r, up to 15, and later ones are dropped
    // so output rate follows input rate up to one pulse per HI_CYCLES+1 cycles, the gap shrinking to one cycle
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            width_r <= 17'h00000;
            busy_r  <= 1'b0;
            pend_r  <= {PEND_W{1'b0}};
        end else begin
            if (busy_r) begin
                if (width_r == 17'h00001) begin
                    busy_r <= 1'b0; // one low cycle at least
                end
                width_r <= width_r - 17'h00001;
                if (event_in && (pend_r != {PEND_W{1'b1}})) begin
                    pend_r <= pend_r + {{(PEND_W-1){1'b0}}, 1'b1};
                end
            end else if (event_in || (pend_r != {PEND_W{1'b0}})) begin
                busy_r  <= 1'b1;
                width_r <= HI_CYCLES[16:0];
                if (!event_in) begin
                    pend_r <= pend_r - {{(PEND_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    assign pulse_out = busy_r;
endmodule // dpc_pulse_out
`default_nettype wire

/* File: rtl/dpc_top.v */
// dpc_top.v: two flow pulse counters with hold, reset key, select key
// assumes pins are asynchronous and keys are active-high mechanical buttons
`timescale 1ns/1ns
`default_nettype none
`include "dpc_consts.vh"

module dpc_top #(
    parameter integer CLK_HZ    = `DPC_CLK_HZ,
    parameter integer IN_MIN_US = `DPC_IN_MIN_US,
    parameter integer OUT_US    = `DPC_OUT_MIN_US + `DPC_OUT_MARGIN_US,
    parameter integer KEY_DB_US = `DPC_KEY_DB_US
) (
    input  wire        sys_clk_in,
    input  wire        sys_rst_in,
    input  wire        flow_channel_one_in,
    input  wire        flow_channel_two_in,
    input  wire        hold_in,
    input  wire        reset_key_in,
    input  wire        select_key_in,
    input  wire        two_channel_in,
    output reg  [27:0] disp_count_out,
    output reg         disp_sel_two_out,
    output reg         ovf_one_out,
    output reg         ovf_two_out,
    output wire        pulse_one_out,
    output wire        pulse_two_out
);
    // least input width in cycles, rounded down so a 1 ms pulse always passes
    localparam integer IN_MIN_CYC  = (CLK_HZ / 1000) * IN_MIN_US / 1000;
    localparam integer IN_FILT_CYC = IN_MIN_CYC / 2;
    // output width rounded up
    localparam integer OUT_CYC     = ((CLK_HZ / 1000) * OUT_US + 999) / 1000;
    localparam integer KEY_DB_CYC  = (CLK_HZ / 1000) * KEY_DB_US / 1000;

    // bcd increment over seven digits, with wrap to zero at the maximum
    // seven packed digits are needed to reach the full count before overflow
    function [27:0] bcd_inc;
        input [27:0] v;
        reg   [27:0] d;
        reg          c;
        integer      i;
        begin
            d = v;
            c = 1'b1;
            for (i = 0; i < 7; i = i + 1) begin
                if (c) begin
                    if (d[i*4 +: 4] == 4'h9) begin
                        d[i*4 +: 4] = 4'h0;
                    end else begin
                        d[i*4 +: 4] = d[i*4 +: 4] + 4'h1;
                        c = 1'b0;
                    end
                end
            end
            bcd_inc = d;
        end
    endfunction

    // two-flop synchronisers for every pin except sys_rst_in, which is used directly
    reg [1:0] s_one_r;
    reg [1:0] s_two_r;
    reg [1:0] s_hold_r;
    reg [1:0] s_rkey_r;
    reg [1:0] s_skey_r;
    reg [1:0] s_cfg_r;
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            s_one_r  <= 2'h0;
            s_two_r  <= 2'h0;
            s_hold_r <= 2'h0; // floating hold pulls low here
            s_rkey_r <= 2'h0;
            s_skey_r <= 2'h0;
            s_cfg_r  <= 2'h0;
        end else begin
            s_one_r  <= {s_one_r[0], flow_channel_one_in};
            s_two_r  <= {s_two_r[0], flow_channel_two_in};
            s_hold_r <= {s_hold_r[0], hold_in};
            s_rkey_r <= {s_rkey_r[0], reset_key_in};
            s_skey_r <= {s_skey_r[0], select_key_in};
            s_cfg_r  <= {s_cfg_r[0], two_channel_in};
        end
    end

    // glitch filter on inputs: only half the least width, no contact debounce
    reg [15:0] f_one_r;
    reg [15:0] f_two_r;
    reg        lv_one_r;
    reg        lv_two_r;
    reg        lv_one_d_r;
    reg        lv_two_d_r;
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            f_one_r    <= 16'h0000;
            f_two_r    <= 16'h0000;
            lv_one_r   <= 1'b0;
            lv_two_r   <= 1'b0;
            lv_one_d_r <= 1'b0;
            lv_two_d_r <= 1'b0;
        end else begin
            lv_one_d_r <= lv_one_r;
            lv_two_d_r <= lv_two_r;
            if (s_one_r[1] == lv_one_r) begin
                f_one_r <= 16'h0000;
            end else if (f_one_r == IN_FILT_CYC[15:0]) begin
                lv_one_r <= s_one_r[1];
                f_one_r  <= 16'h0000;
            end else begin
                f_one_r <= f_one_r + 16'h0001;
            end
            if (s_two_r[1] == lv_two_r) begin
                f_two_r <= 16'h0000;
            end else if (f_two_r == IN_FILT_CYC[15:0]) begin
                lv_two_r <= s_two_r[1];
                f_two_r  <= 16'h0000;
            end else begin
                f_two_r <= f_two_r + 16'h0001;
            end
        end
    end

    wire ev_one = lv_one_r & ~lv_one_d_r;
    wire ev_two = lv_two_r & ~lv_two_d_r & s_cfg_r[1];

    // key debounce: keys are slow, so a long stable time is affordable
    reg [19:0] kr_cnt_r;
    reg [19:0] ks_cnt_r;
    reg        kr_lv_r;
    reg        ks_lv_r;
    reg        kr_ev_r;
    reg        ks_ev_r;
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            kr_cnt_r <= 20'h00000;
            ks_cnt_r <= 20'h00000;
            kr_lv_r  <= 1'b0;
            ks_lv_r  <= 1'b0;
            kr_ev_r  <= 1'b0;
            ks_ev_r  <= 1'b0;
        end else begin
            kr_ev_r <= 1'b0;
            ks_ev_r <= 1'b0;
            if (s_rkey_r[1] == kr_lv_r) begin
                kr_cnt_r <= 20'h00000;
            end else if (kr_cnt_r == KEY_DB_CYC[19:0]) begin
                kr_lv_r  <= s_rkey_r[1];
                kr_ev_r  <= s_rkey_r[1];
                kr_cnt_r <= 20'h00000;
            end else begin
                kr_cnt_r <= kr_cnt_r + 20'h00001;
            end
            if (s_skey_r[1] == ks_lv_r) begin
                ks_cnt_r <= 20'h00000;
            end else if (ks_cnt_r == KEY_DB_CYC[19:0]) begin
                ks_lv_r  <= s_skey_r[1];
                ks_ev_r  <= s_skey_r[1];
                ks_cnt_r <= 20'h00000;
            end else begin
                ks_cnt_r <= ks_cnt_r + 20'h00001;
            end
        end
    end

    // counters in packed bcd; reset key beats a coincident pulse
    reg [27:0] cnt_one_r;
    reg [27:0] cnt_two_r;
    wire       run = ~s_hold_r[1];
    always @(posedge sys_clk_in) begin
        if (sys_rst_in || kr_ev_r) begin
            cnt_one_r   <= `DPC_CNT_ZERO;
            cnt_two_r   <= `DPC_CNT_ZERO;
            ovf_one_out <= 1'b0;
            ovf_two_out <= 1'b0;
        end else begin
            if (ev_one && run) begin
                cnt_one_r <= bcd_inc(cnt_one_r);
                if (cnt_one_r == `DPC_CNT_MAX) begin
                    ovf_one_out <= 1'b1;
                end
            end
            if (ev_two && run) begin
                cnt_two_r <= bcd_inc(cnt_two_r);
                if (cnt_two_r == `DPC_CNT_MAX) begin
                    ovf_two_out <= 1'b1;
                end
            end
        end
    end

    // display select; falls back to channel one when only one is fitted
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            disp_sel_two_out <= 1'b0;
            disp_count_out   <= `DPC_CNT_ZERO;
        end else begin
            if (!s_cfg_r[1]) begin
                disp_sel_two_out <= 1'b0;
            end else if (ks_ev_r) begin
                disp_sel_two_out <= ~disp_sel_two_out;
            end
            disp_count_out <= disp_sel_two_out ? cnt_two_r : cnt_one_r;
        end
    end

    // output pulses run regardless of hold, as the bench counts them itself
    dpc_pulse_out #(
        .HI_CYCLES (OUT_CYC)
    ) u_out_one (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .event_in   (ev_one),
        .pulse_out  (pulse_one_out)
    );

    dpc_pulse_out #(
        .HI_CYCLES (OUT_CYC)
    ) u_out_two (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .event_in   (ev_two),
        .pulse_out  (pulse_two_out)
    );
endmodule // dpc_top
`default_nettype wire

/* File: tb/dpc_chk_assertions.sv */
// dpc_chk_assertions.sv: port checker for the dual pulse counter
// assumes one clock domain and the synchronous reset of dpc_top
`timescale 1ns/1ns
`default_nettype none
module dpc_chk #(
    parameter integer CLK_HZ = 25000000,
    parameter integer OUT_US = 4100
) (
    input wire logic        sys_clk_in,
    input wire logic        sys_rst_in,
    input wire logic        hold_in,
    input wire logic        reset_key_in,
    input wire logic        select_key_in,
    input wire logic        two_channel_in,
    input wire logic [27:0] disp_count_out,
    input wire logic        disp_sel_two_out,
    input wire logic        ovf_one_out,
    input wire logic        pulse_one_out,
    input wire logic        pulse_two_out
);
    localparam integer OUT_CYC = CLK_HZ / 1000000 * OUT_US;
    integer hi_cnt_r;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // length of the running high phase of output one
    always @(posedge sys_clk_in) begin
        if (sys_rst_in || !pulse_one_out) hi_cnt_r <= 0;
        else hi_cnt_r <= hi_cnt_r + 1;
    end
    a_pulse_high_len: assert property (
        $fell(pulse_one_out) |-> hi_cnt_r == OUT_CYC) else $error("output pulse length");
    a_pulse_low_gap: assert property (
        pulse_one_out && hi_cnt_r == OUT_CYC - 1 |=> !pulse_one_out)
        else $error("no gap between pulses");
    // a display switch also moves the count, so the channel must be settled
    a_hold_freeze: assert property (
        hold_in && $past(hold_in, 8) && $stable(disp_sel_two_out)
        && disp_sel_two_out == $past(disp_sel_two_out, 2)
        |-> $stable(disp_count_out) || disp_count_out == 28'h0000000)
        else $error("count moved under hold");
    a_count_step: assert property (
        $changed(disp_count_out) && $stable(disp_sel_two_out)
        && disp_sel_two_out == $past(disp_sel_two_out, 2)
        && $past(disp_count_out[3:0]) < 4'h9 && disp_count_out != 28'h0000000
        |-> disp_count_out == $past(disp_count_out) + 28'h0000001)
        else $error("count step not one");
    a_sel_by_key: assert property (
        $changed(disp_sel_two_out) |-> $past(select_key_in, 2) || !$past(two_channel_in, 3))
        else $error("select moved");
    a_ovf_clear: assert property (
        $fell(ovf_one_out) |-> $past(reset_key_in, 2)) else $error("overflow flag lost");
    a_ovf_wrap: assert property (
        $rose(ovf_one_out) && !disp_sel_two_out && $stable(disp_sel_two_out)
        |=> disp_count_out == 28'h0000000) else $error("no wrap on overflow");
    a_chan_two_off: assert property (
        $rose(pulse_two_out) |-> two_channel_in) else $error("channel two not off");
    cover property ($rose(pulse_one_out));
    cover property (hold_in && $rose(pulse_one_out));
    cover property ($changed(disp_sel_two_out));
endmodule // dpc_chk
bind dpc_top dpc_chk #(.CLK_HZ(CLK_HZ), .OUT_US(OUT_US)) u_chk (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .hold_in(hold_in),
    .reset_key_in(reset_key_in), .select_key_in(select_key_in),
    .two_channel_in(two_channel_in), .disp_count_out(disp_count_out),
    .disp_sel_two_out(disp_sel_two_out), .ovf_one_out(ovf_one_out),
    .pulse_one_out(pulse_one_out), .pulse_two_out(pulse_two_out));
`default_nettype wire

/* File: tb/dpc_sensor.sv */
// dpc_sensor.sv: flow sensor pair and hold line of the test rig
// assumes a bench clock; the board pulls an open hold line low
`timescale 1ns/1ns
`default_nettype none
module dpc_sensor (
    input  wire logic clk_in,
    output var logic  line_one_out,
    output var logic  line_two_out,
    output var logic  hold_out
);
    initial begin
        line_one_out = 1'b0;
        line_two_out = 1'b0;
        hold_out = 1'b0;
    end
    // clean edges only: contact bounce would count twice
    task automatic burst(input int ch, input int n, input int cyc);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            if (ch == 1) line_one_out <= 1'b1;
            else line_two_out <= 1'b1;
            repeat (cyc) @(posedge clk_in);
            line_one_out <= 1'b0;
            line_two_out <= 1'b0;
            repeat (cyc) @(posedge clk_in);
        end
    endtask
    task automatic set_hold(input logic v);
        @(posedge clk_in);
        hold_out <= v;
    endtask
endmodule // dpc_sensor
`default_nettype wire

/* File: tb/tb.sv */
// tb.sv: scenario bench for dpc_top with shortened time counts
// assumes dpc_sensor drives the flow and hold lines
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam integer PW = 110; // above the 100 cycle minimum width
    logic sys_clk = 1'b0, sys_rst = 1'b1, rkey = 1'b0, skey = 1'b0, two_ch = 1'b1;
    logic p1_q = 1'b0, p2_q = 1'b0;
    wire f1, f2, hold, sel, ov1, ov2, p1, p2;
    wire [27:0] cnt;
    int n_fail = 0, comparisons = 0, cycles = 0, n_p1 = 0, n_p2 = 0;
    always #20 sys_clk = ~sys_clk;
    dpc_sensor sen (.clk_in(sys_clk), .line_one_out(f1), .line_two_out(f2), .hold_out(hold));
    dpc_top #(.IN_MIN_US(4), .OUT_US(8), .KEY_DB_US(4)) dut (
        .sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .flow_channel_one_in(f1),
        .flow_channel_two_in(f2), .hold_in(hold), .reset_key_in(rkey),
        .select_key_in(skey), .two_channel_in(two_ch), .disp_count_out(cnt),
        .disp_sel_two_out(sel), .ovf_one_out(ov1), .ovf_two_out(ov2),
        .pulse_one_out(p1), .pulse_two_out(p2));
    // output pulse counting and run ceiling
    always @(posedge sys_clk) begin
        p1_q <= p1;
        p2_q <= p2;
        if (p1 === 1'b1 && p1_q === 1'b0) n_p1 <= n_p1 + 1;
        if (p2 === 1'b1 && p2_q === 1'b0) n_p2 <= n_p2 + 1;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail = n_fail + 1;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // key held well past the debounce time, then released as long
    task automatic press(input int is_reset);
        @(posedge sys_clk);
        if (is_reset == 1) rkey <= 1'b1;
        else skey <= 1'b1;
        repeat (300) @(posedge sys_clk);
        rkey <= 1'b0;
        skey <= 1'b0;
        repeat (300) @(posedge sys_clk);
    endtask
    task automatic t_count;
        sen.burst(1, 10, PW);
        repeat (500) @(posedge sys_clk);
        check("count one", cnt, 28'h0000010);
        check("pulses one", 28'(n_p1), 28'h000000A);
        $display("test count done");
    endtask
    task automatic t_hold;
        sen.set_hold(1'b1);
        repeat (20) @(posedge sys_clk);
        sen.burst(1, 2, PW);
        repeat (500) @(posedge sys_clk);
        check("held count", cnt, 28'h0000010);
        check("held pulses", 28'(n_p1), 28'h000000C);
        sen.set_hold(1'b0);
        repeat (20) @(posedge sys_clk);
        sen.burst(1, 1, PW);
        repeat (500) @(posedge sys_clk);
        check("resumed count", cnt, 28'h0000011);
        $display("test hold done");
    endtask
    task automatic t_select;
        press(0);
        check("select", 28'(sel), 28'h0000001);
        check("count two", cnt, 28'h0000000);
        sen.burst(2, 3, PW);
        repeat (500) @(posedge sys_clk);
        check("count two", cnt, 28'h0000003);
        check("pulses two", 28'(n_p2), 28'h0000003);
        $display("test select done");
    endtask
    // single channel base: channel two is ignored and display falls back to one
    task automatic t_chan_off;
        @(posedge sys_clk);
        two_ch <= 1'b0;
        sen.burst(2, 1, PW);
        repeat (500) @(posedge sys_clk);
        check("shown one", cnt, 28'h0000011);
        check("select fallback", 28'(sel), 28'h0000000);
        check("pulses two off", 28'(n_p2), 28'h0000003);
        two_ch <= 1'b1;
        $display("test channel off done");
    endtask
    task automatic t_reset;
        press(1);
        check("cleared one", cnt, 28'h0000000);
        press(0);
        check("select again", 28'(sel), 28'h0000001);
        check("cleared two", cnt, 28'h0000000);
        check("no overflow", 28'({ov2, ov1}), 28'h0000000);
        $display("test reset key done");
    endtask
    task give_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_count();
        t_hold();
        t_select();
        t_chan_off();
        t_reset();
        give_verdict();
    end
endmodule // tb
`default_nettype wire
